// ### src/dram_seq_device.sv
// DRAM controller end: single read sequencing, page compare and precharge
`timescale 1ns/1ps
`include "dram_seq_consts.svh"

// Notes on behaviour
// R1 - Bank parity high for even, low odd
// R2 - Column strobes follow requested byte lanes only
// R3 - Start on address latch plus read strobe
// R4 - Latch address, split, drive row part
// R5 - Fast select: late chip select means foreign
// R6 - Slow select: decoder valid by next fall
// R7 - Row strobe on rise; enable ack lines high
// R8 - Delay 0: column at fall, strobe next rise
// R9 - Delay 1: column 1.5 cycles later, strobe
// R10 - Column strobe width 1.5/2.5, end on fall
// R11 - Ack and capture one cycle, before negate
// R12 - Processor samples data at strobe negate
// R13 - Row strobe stays asserted after read
// R14 - Compare page bits; size sets page
// R15 - Page hit: column only, strobe per mode
// R16 - Page miss: row out, negate, restart
// R17 - Precharge at least 2 cycles
// R18 - Processor uses single reads for uncached
// R19 - Same-page write hint on 22-bit match; host here keeps it negated
// R20 - One row strobe per bank, shared columns
// R21 - Transceiver direction low for reads
// R22 - Reset: strobes negated, no page open
module dram_seq_device
  import dram_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  dram_seq_if.device bus,
  input wire logic slow_select_mode_bit_i,
  input wire logic row_to_column_delay_bit_i,
  input wire logic cas_width_long_i,
  input wire logic [`PRE_W-1:0] precharge_extra_i,
  input wire logic [`SIZE_W-1:0] dram_size_i,
  output logic page_open_o,
  output logic busy_o
);
  import dram_seq_pkg::*;

  function automatic logic [`DRAM_ADDRESS_BUS_W-1:0] col_of(input logic [`WADDR_W-1:0] w, input logic [`SIZE_W-1:0] sz);
    logic [`WADDR_W-1:0] m;
    m = ~({`WADDR_W{1'b1}} << (`MIN_COL_W + sz));
    col_of = `DRAM_ADDRESS_BUS_W'(w & m);
  endfunction

  function automatic logic [`WADDR_W-1:0] page_of(input logic [`WADDR_W-1:0] w, input logic [`SIZE_W-1:0] sz);
    page_of = w >> (`MIN_COL_W + sz);
  endfunction

  function automatic logic [`DRAM_ADDRESS_BUS_W-1:0] row_of(input logic [`WADDR_W-1:0] w, input logic [`SIZE_W-1:0] sz);
    row_of = col_of(page_of(w, sz), sz);
  endfunction

  function automatic logic [`BANK_W-1:0] bank_of(input logic [`WADDR_W-1:0] w, input logic [`SIZE_W-1:0] sz);
    bank_of = `BANK_W'(page_of(page_of(w, sz), sz));
  endfunction

  dev_state_type state_ff;
  logic phase_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic [`WADDR_W-1:0] waddr_ff;
  logic [`LANES-1:0] lanes_n_ff;
  logic [`WADDR_W-1:0] open_page_ff;
  logic page_open_ff;
  logic [`LANES-1:0] row_strobe_n_ff;
  logic [`LANES-1:0] column_strobe_n_ff;
  logic [`DRAM_ADDRESS_BUS_W-1:0] dram_address_bus_ff;
  logic ack_n_ff;
  logic capture_n_ff;
  logic drive_ff;
  logic parity_ff;
  logic dir_ff;
  logic rise;
  logic cnt_done;
  logic start;
  logic page_hit;
  logic [`WADDR_W-1:0] waddr_in;
  logic [`CNT_W-1:0] to_rise;
  logic [`BANK_W-1:0] start_bank;

  // A rise tick is one that raises the system clock, flagged while the clock is low
  assign rise = ~phase_ff;
  assign cnt_done = (cnt_ff == `CNT_ZERO);
  assign waddr_in = bus.proc_address[`ADDR_W-1:`WORD_LSB];
  assign start = bus.addr_latch_strobe & ~bus.read_strobe_n; // see R3
  assign page_hit = page_open_ff && (page_of(waddr_ff, dram_size_i) == open_page_ff); // see R14
  assign to_rise = `CNT_W'(rise);
  assign start_bank = bank_of(waddr_in, dram_size_i);

  // System clock for both ends, one half cycle per tick
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // Transceiver direction: this block only reads
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dir_ff <= 1'b0;
    end else begin
      dir_ff <= 1'b0; // see R21
    end
  end

  // Access sequencing and memory controls
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= st_idle;
      cnt_ff <= `CNT_ZERO;
      waddr_ff <= '0;
      lanes_n_ff <= `LANES_OFF;
      open_page_ff <= '0;
      page_open_ff <= 1'b0; // see R22
      row_strobe_n_ff <= `BANKS_OFF; // see R22
      column_strobe_n_ff <= `LANES_OFF; // see R22
      dram_address_bus_ff <= '0;
      ack_n_ff <= 1'b1;
      capture_n_ff <= 1'b1;
      drive_ff <= 1'b0;
      parity_ff <= 1'b1;
    end else begin
      if (!cnt_done) begin
        cnt_ff <= cnt_ff - `CNT_ONE;
      end
      unique case (state_ff)
        st_idle: begin
          if (start) begin
            waddr_ff <= waddr_in; // see R4
            lanes_n_ff <= bus.byte_lane_enable_n;
            dram_address_bus_ff <= row_of(waddr_in, dram_size_i); // see R4
            parity_ff <= ~start_bank[0]; // see R1
            // Fast mode decides on the next rise, slow one edge later
            cnt_ff <= `CNT_W'(rise) + `CNT_W'(slow_select_mode_bit_i); // see R5 R6
            state_ff <= st_decide;
          end
        end
        st_decide: begin
          if (cnt_done) begin
            cnt_ff <= to_rise;
            if (bus.chip_select_n) begin
              state_ff <= st_idle; // see R5
            end else if (page_hit) begin
              dram_address_bus_ff <= col_of(waddr_ff, dram_size_i); // see R15
              drive_ff <= 1'b1;
              state_ff <= st_cas_wait; // see R15
            end else if (page_open_ff) begin
              state_ff <= st_pre_wait; // see R16
            end else begin
              state_ff <= st_ras_wait;
            end
          end
        end
        st_pre_wait: begin
          if (cnt_done) begin
            row_strobe_n_ff <= `BANKS_OFF; // see R16
            page_open_ff <= 1'b0;
            cnt_ff <= `CNT_W'((precharge_extra_i + `PRE_MIN_CYC) << 1) - `CNT_ONE; // see R17
            state_ff <= st_precharge;
          end
        end
        st_precharge, st_ras_wait: begin
          if (cnt_done) begin
            // One row strobe selects one bank
            row_strobe_n_ff <= ~(`ONE_BANK << bank_of(waddr_ff, dram_size_i)); // see R7 R20
            drive_ff <= 1'b1; // see R7
            open_page_ff <= page_of(waddr_ff, dram_size_i); // see R14
            page_open_ff <= 1'b1;
            cnt_ff <= row_to_column_delay_bit_i ? `RCD_LONG_TICKS : `RCD_SHORT_TICKS; // see R8 R9
            state_ff <= st_ras_on;
          end
        end
        st_ras_on: begin
          if (cnt_done) begin
            dram_address_bus_ff <= col_of(waddr_ff, dram_size_i); // see R8 R9
            state_ff <= st_cas_wait;
          end
        end
        st_cas_wait: begin
          if (cnt_done) begin
            column_strobe_n_ff <= lanes_n_ff; // see R2 R20
            cnt_ff <= cas_width_long_i ? `CAS_LONG_TICKS : `CAS_SHORT_TICKS; // see R10
            state_ff <= st_cas_on;
          end
        end
        st_cas_on: begin
          if (cnt_ff == `ACK_TICK) begin
            ack_n_ff <= 1'b0; // see R11
            capture_n_ff <= 1'b0; // see R11
          end
          if (cnt_done) begin
            // Negation lands on a falling edge, where data is sampled
            column_strobe_n_ff <= `LANES_OFF; // see R10 R12
            ack_n_ff <= 1'b1; // see R11
            capture_n_ff <= 1'b1;
            drive_ff <= 1'b0;
            state_ff <= st_idle; // see R13
          end
        end
      endcase
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      page_open_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      page_open_o <= page_open_ff;
      busy_o <= (state_ff != st_idle) || start;
    end
  end

  assign bus.system_clock = phase_ff;
  assign bus.ack_n = ack_n_ff;
  assign bus.ack_oe = drive_ff;
  assign bus.read_capture_enable_n = capture_n_ff;
  assign bus.read_capture_oe = drive_ff;
  assign bus.dram_address_bus = dram_address_bus_ff;
  assign bus.row_strobe_n = row_strobe_n_ff;
  assign bus.column_strobe_n = column_strobe_n_ff;
  assign bus.bank_parity = parity_ff;
  assign bus.transceiver_dir = dir_ff;

endmodule // dram_seq_device

// ### common/dram_seq_consts.svh
// Shared widths, timing counts and mode encodings for the single read sequencer
`ifndef DRAM_SEQ_CONSTS_SVH
`define DRAM_SEQ_CONSTS_SVH

`define ADDR_W 28
`define WADDR_W 26
`define WORD_LSB 2
`define DRAM_ADDRESS_BUS_W 11
`define LANES 4
`define BANK_W 2
`define SIZE_W 2
`define PRE_W 2
`define CNT_W 4
`define MIN_COL_W 9
`define LANES_OFF 4'hf
`define BANKS_OFF 4'hf
`define ONE_BANK 4'h1
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define PRE_MIN_CYC 4'h2
`define RCD_LONG_TICKS 4'h2
`define RCD_SHORT_TICKS 4'h0
`define CAS_LONG_TICKS 4'h4
`define CAS_SHORT_TICKS 4'h2
`define ACK_TICK 4'h2
`define ALE_TICKS 2'h1
`define FOREIGN_TICKS 2'h3

`endif

// ### common/dram_seq_pkg.sv
// Types shared by both ends of the single read sequencer
package dram_seq_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_decide,
    st_pre_wait,
    st_precharge,
    st_ras_wait,
    st_ras_on,
    st_cas_wait,
    st_cas_on
  } dev_state_type;

  typedef enum logic [1:0] {
    hs_idle,
    hs_addr,
    hs_wait,
    hs_sample
  } host_state_type;

endpackage

// ### common/dram_seq_if.sv
// Processor bus and DRAM pins joining the sequencer to the processor end
`timescale 1ns/1ps
`include "dram_seq_consts.svh"

interface dram_seq_if;
  logic system_clock;
  logic addr_latch_strobe;
  logic read_strobe_n;
  logic chip_select_n;
  logic same_page_write_hint_n;
  logic [`ADDR_W-1:0] proc_address;
  logic [`LANES-1:0] byte_lane_enable_n;
  logic ack_n;
  logic ack_oe;
  logic read_capture_enable_n;
  logic read_capture_oe;
  logic [`DRAM_ADDRESS_BUS_W-1:0] dram_address_bus;
  logic [`LANES-1:0] row_strobe_n;
  logic [`LANES-1:0] column_strobe_n;
  logic bank_parity;
  logic transceiver_dir;

  modport device (
    output system_clock,
    input addr_latch_strobe,
    input read_strobe_n,
    input chip_select_n,
    input same_page_write_hint_n,
    input proc_address,
    input byte_lane_enable_n,
    output ack_n,
    output ack_oe,
    output read_capture_enable_n,
    output read_capture_oe,
    output dram_address_bus,
    output row_strobe_n,
    output column_strobe_n,
    output bank_parity,
    output transceiver_dir
  );

  modport host (
    input system_clock,
    output addr_latch_strobe,
    output read_strobe_n,
    output chip_select_n,
    output same_page_write_hint_n,
    output proc_address,
    output byte_lane_enable_n,
    input ack_n,
    input ack_oe,
    input read_capture_enable_n,
    input read_capture_oe
  );
endinterface

// ### src/dram_seq_host.sv
// Processor end: issues single word reads and waits for acknowledge
`timescale 1ns/1ps
`include "dram_seq_consts.svh"

module dram_seq_host
  import dram_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  dram_seq_if.host bus,
  input wire logic read_req_i,
  input wire logic [`ADDR_W-1:0] read_address_i,
  input wire logic [`LANES-1:0] read_byte_en_i,
  input wire logic in_range_i,
  output logic busy_o,
  output logic done_o,
  output logic acked_o
);
  import dram_seq_pkg::*;

  host_state_type state_ff;
  logic [1:0] cnt_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic cs_n_ff;
  logic hint_n_ff;
  logic [`ADDR_W-1:0] addr_ff;
  logic [`LANES-1:0] be_n_ff;
  logic rise;

  assign rise = ~bus.system_clock;

  // Write hint stays negated: no writes issued here
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hint_n_ff <= 1'b1;
    end else begin
      hint_n_ff <= 1'b1; // see R19
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= hs_idle;
      cnt_ff <= '0;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      addr_ff <= '0;
      be_n_ff <= `LANES_OFF;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      acked_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_ff)
        hs_idle: begin
          if (read_req_i && rise) begin
            // Every access is a single word read
            ale_ff <= 1'b1; // see R18
            rd_n_ff <= 1'b0;
            cs_n_ff <= ~in_range_i; // see R6
            addr_ff <= read_address_i;
            be_n_ff <= ~read_byte_en_i;
            busy_o <= 1'b1;
            acked_o <= 1'b0;
            cnt_ff <= '0;
            state_ff <= hs_addr;
          end
        end
        hs_addr: begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == `ALE_TICKS) begin
            ale_ff <= 1'b0;
            if (!cs_n_ff) begin
              state_ff <= hs_wait;
            end
          end
          if (cnt_ff == `FOREIGN_TICKS) begin
            rd_n_ff <= 1'b1;
            cs_n_ff <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_ff <= hs_idle;
          end
        end
        hs_wait: begin
          if (bus.ack_oe && !bus.ack_n) begin
            state_ff <= hs_sample;
          end
        end
        hs_sample: begin
          // Data taken on the falling edge one cycle after acknowledge
          if (!rise) begin
            rd_n_ff <= 1'b1; // see R12
            cs_n_ff <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            acked_o <= 1'b1;
            state_ff <= hs_idle;
          end
        end
      endcase
    end
  end

  assign bus.addr_latch_strobe = ale_ff;
  assign bus.read_strobe_n = rd_n_ff;
  assign bus.chip_select_n = cs_n_ff;
  assign bus.same_page_write_hint_n = hint_n_ff;
  assign bus.proc_address = addr_ff;
  assign bus.byte_lane_enable_n = be_n_ff;

endmodule // dram_seq_host

// ### verification/dram_seq_props.sv
// Timing checks on the sequencer pins between the two ends
`timescale 1ns/1ps

module dram_seq_props (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ack_n,
  input wire logic ack_oe,
  input wire logic read_capture_enable_n,
  input wire logic read_capture_oe,
  input wire logic [3:0] row_strobe_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic transceiver_dir
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [3:0] hi_cnt_ff;
  wire cas_on = !(&column_strobe_n);

  // Ticks with every row strobe negated, saturating
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !(&row_strobe_n)) hi_cnt_ff <= 4'h0;
    else if (hi_cnt_ff != 4'hf) hi_cnt_ff <= hi_cnt_ff + 4'h1;
  end

  a_ack_cap_pair: assert property (ack_oe |-> ack_n == read_capture_enable_n)
    else $error("ack and capture differ");
  a_ack_one_cycle: assert property ($fell(ack_n) |=> !ack_n ##1 ack_n)
    else $error("ack width wrong");
  a_cas_end_ack: assert property ($fell(ack_n) |-> ##2 $rose(&column_strobe_n))
    else $error("column strobes not ended after ack");
  a_cas_width_ok: assert property ($rose(cas_on) |-> cas_on[*3] ##1 (!cas_on or cas_on[*2] ##1 !cas_on))
    else $error("column strobe width wrong");
  a_ras_kept_open: assert property ($rose(ack_n) |-> row_strobe_n != 4'hf && $stable(row_strobe_n))
    else $error("row closed after read");
  a_one_row_bank: assert property ($onehot0(~row_strobe_n))
    else $error("several row strobes");
  a_precharge_min: assert property ($fell(&row_strobe_n) |-> hi_cnt_ff >= 4'h4)
    else $error("precharge too short");
  a_dir_is_read: assert property (transceiver_dir == 1'b0)
    else $error("direction not read");
  a_cas_needs_row: assert property (cas_on |-> row_strobe_n != 4'hf)
    else $error("column strobe without row");
  a_ack_driven: assert property (!ack_n |-> ack_oe && read_capture_oe)
    else $error("ack asserted undriven");
  a_oe_rise_high: assert property ($rose(ack_oe) |-> ack_n && read_capture_enable_n)
    else $error("ack lines not driven high first");

  c_read_done: cover property ($fell(ack_n));
  c_precharge: cover property ($rose(&row_strobe_n));
  c_long_cas: cover property ($rose(cas_on) ##5 !cas_on);
endmodule // dram_seq_props

// ### verification/dram_single_read_sequencer_tb_top.sv
// Bench joining both sequencer ends and driving single reads
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end

module dram_single_read_sequencer_tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req = 1'b0, inr = 1'b0, slow = 1'b0, row_to_column_delay_bit = 1'b0, cas_long = 1'b0;
  logic [27:0] addr = 28'h0;
  logic [3:0] be = 4'h0, lanes;
  logic [1:0] pre_x = 2'h0, size = 2'h0;
  logic page_open, dbusy, hbusy, done, acked, par;
  logic [10:0] ra, ca;
  logic seen_busy;
  int num_errors = 0, checks_done = 0, hi;

  always #2.5 ref_clk_i = ~ref_clk_i;

  dram_seq_if dram_seq_if_i ();
  dram_seq_device dram_seq_device_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(dram_seq_if_i.device),
    .slow_select_mode_bit_i(slow), .row_to_column_delay_bit_i(row_to_column_delay_bit), .cas_width_long_i(cas_long),
    .precharge_extra_i(pre_x), .dram_size_i(size), .page_open_o(page_open), .busy_o(dbusy));
  dram_seq_host dram_seq_host_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(dram_seq_if_i.host),
    .read_req_i(req), .read_address_i(addr), .read_byte_en_i(be), .in_range_i(inr),
    .busy_o(hbusy), .done_o(done), .acked_o(acked));
  dram_seq_props dram_seq_props_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ack_n(dram_seq_if_i.ack_n),
    .ack_oe(dram_seq_if_i.ack_oe), .read_capture_enable_n(dram_seq_if_i.read_capture_enable_n),
    .read_capture_oe(dram_seq_if_i.read_capture_oe), .row_strobe_n(dram_seq_if_i.row_strobe_n),
    .column_strobe_n(dram_seq_if_i.column_strobe_n), .transceiver_dir(dram_seq_if_i.transceiver_dir));

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One read; records lanes seen, row-closed ticks and parity
  task automatic rd(input logic [27:0] a, input logic [3:0] b, input logic r);
    int n;
    lanes = 4'h0;
    hi = 0;
    ra = 11'h7ff;
    ca = 11'h7ff;
    seen_busy = 1'b0;
    @(posedge ref_clk_i);
    addr <= a;
    be <= b;
    inr <= r;
    req <= 1'b1;
    n = 0;
    do begin @(negedge ref_clk_i); n++; end while (hbusy !== 1'b1 && n < 50);
    @(posedge ref_clk_i);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
      lanes |= ~dram_seq_if_i.column_strobe_n;
      if (dram_seq_if_i.row_strobe_n === 4'hf) begin
        hi++;
        ra = dram_seq_if_i.dram_address_bus;
      end
      if (dram_seq_if_i.column_strobe_n !== 4'hf) ca = dram_seq_if_i.dram_address_bus;
      if (dbusy === 1'b1) seen_busy = 1'b1;
      par = dram_seq_if_i.bank_parity;
    end
    `CHK(done, 1'b1)
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic t_first;
    rd(28'h0101804, 4'h5, 1'b1);
    `CHK(lanes, 4'h5)
    `CHK(par, 1'b0)
    `CHK(dram_seq_if_i.row_strobe_n, 4'hd)
    `CHK(acked, 1'b1)
    `CHK(page_open, 1'b1)
    `CHK(ra, 11'h003)
    `CHK(ca, 11'h001)
    `CHK(hi, 3)
    `CHK(seen_busy, 1'b1)
    `CHK(dram_seq_if_i.same_page_write_hint_n, 1'b1)
  endtask

  task automatic t_hit;
    rd(28'h0101850, 4'ha, 1'b1);
    `CHK(hi, 0)
    `CHK(ca, 11'h014)
    `CHK(lanes, 4'ha)
    `CHK(dram_seq_if_i.row_strobe_n, 4'hd)
  endtask

  task automatic t_miss;
    @(posedge ref_clk_i);
    pre_x <= 2'h1;
    rd(28'h0202800, 4'h3, 1'b1);
    `CHK(hi, 6)
    `CHK(ra, 11'h005)
    `CHK(par, 1'b1)
    `CHK(dram_seq_if_i.row_strobe_n, 4'hb)
  endtask

  task automatic t_foreign;
    rd(28'h0000000, 4'hf, 1'b0);
    `CHK(lanes, 4'h0)
    `CHK(acked, 1'b0)
    `CHK(dram_seq_if_i.row_strobe_n, 4'hb)
    `CHK(page_open, 1'b1)
  endtask

  task automatic t_slow_long;
    @(posedge ref_clk_i);
    slow <= 1'b1;
    row_to_column_delay_bit <= 1'b1;
    cas_long <= 1'b1;
    pre_x <= 2'h0;
    rd(28'h0300800, 4'hf, 1'b1);
    `CHK(hi, 4)
    `CHK(ra, 11'h001)
    `CHK(ca, 11'h000)
    `CHK(lanes, 4'hf)
    `CHK(dram_seq_if_i.row_strobe_n, 4'h7)
    `CHK(acked, 1'b1)
  endtask

  task automatic t_reset;
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(dram_seq_if_i.row_strobe_n, 4'hf)
    `CHK(dram_seq_if_i.column_strobe_n, 4'hf)
    `CHK(page_open, 1'b0)
  endtask

  // First read after reset with ten column bits: closed page, no precharge
  task automatic t_size;
    @(posedge ref_clk_i);
    size <= 2'h1;
    rd(28'h0805008, 4'h9, 1'b1);
    `CHK(hi, 3)
    `CHK(lanes, 4'h9)
    `CHK(par, 1'b1)
    `CHK(dram_seq_if_i.row_strobe_n, 4'hb)
    `CHK(ra, 11'h005)
    `CHK(ca, 11'h002)
    `CHK(acked, 1'b1)
    `CHK(page_open, 1'b1)
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_first();
    t_hit();
    t_miss();
    t_foreign();
    t_slow_long();
    t_reset();
    t_size();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule // dram_single_read_sequencer_tb_top
